// *** hw/urbg_map.vh ***
// register map, field positions, reset values and timing counts of the uart block
`ifndef URBG_MAP_VH
`define URBG_MAP_VH
`define URBG_ADDR_CTRL    5'h00
`define URBG_ADDR_DATA    5'h04
`define URBG_ADDR_RATE    5'h08
`define URBG_ADDR_T1CFG   5'h0C
`define URBG_ADDR_T2RLD   5'h10
`define URBG_ADDR_STAT    5'h14
`define URBG_CTRL_SMH     7
`define URBG_CTRL_SML     6
`define URBG_CTRL_MPF     5
`define URBG_CTRL_REN     4
`define URBG_CTRL_TB8     3
`define URBG_CTRL_RB8     2
`define URBG_CTRL_TXF     1
`define URBG_CTRL_RXF     0
`define URBG_RATE_DBL     0
`define URBG_RATE_RSEL    1
`define URBG_RATE_TSEL    2
`define URBG_T1_MODE_LO   8
`define URBG_T1_MODE_HI   9
`define URBG_T1_CNTR      10
`define URBG_T1_RUN       11
`define URBG_CTRL_RST     8'h00
`define URBG_RATE_RST     3'h0
`define URBG_T1CFG_RST    12'h000
`define URBG_T2RLD_RST    16'h0000
`define URBG_MODE_SHIFT   2'h0
`define URBG_MODE_8VAR    2'h1
`define URBG_MODE_9FIX    2'h2
`define URBG_MODE_9VAR    2'h3
`define URBG_M0_DIV_LAST  4'hB
`define URBG_M0_HALF      4'h6
`define URBG_T1_PRE_LAST  4'hB
`define URBG_OVS_LAST     4'hF
`define URBG_RX_MID       4'h7
`define URBG_BITS_8       4'hA
`define URBG_BITS_9       4'hB
`endif

// *** hw/urbg_top.v ***
// serial port with mode control, timer 1 and timer 2 rate generation, avalon slave
`timescale 1ns/1ps
// Functional notes
// - both mode bits set: 9-bit async port, rate from timer overflow
// - mode 3 frames like mode 2, timed like mode 1
// - any write to the serial buffer starts a transmission, every mode
// - shift mode: receive starts while receive flag clear and enable set
// - async modes: receive starts on start bit only while enabled
// - shift mode bit rate is core clock over 12
// - 9-bit fixed mode: clock over 64, or over 32 with doubling
// - variable modes timed by timer 1 or timer 2, per direction
// - timer 1 source: rate is overflow rate times 2^doubling over 32
// - timer 1 usable as timer or counter in all three running modes
// - timer 1 8-bit reload: clock/12/(256-reload) times 2^doubling/32
// - timer 2 source: one bit per 16 overflows
// - timer 2 as rate source counts every two core clocks
// - either timer 2 select bit puts timer 2 in rate mode
// - timer 2 rate is clock/(32*(65536-reload))
// - 9-bit frame: start, 8 data lsb first, ninth bit, stop
// - filter bit set and ninth bit 0, or flag still set: frame lost
// - transmit flag at stop start, receive flag mid stop; software clears
// - shift mode: 8 bits lsb first on data line, clock on other pin
`include "urbg_map.vh"
module urbg_top (
  input  wire        clk_in,
  input  wire        sys_rst_in,
  input  wire [4:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output wire [31:0] avs_readdata_out,
  output wire        avs_waitrequest_out,
  input  wire        serial_data_in,
  output wire        serial_data_out,
  output wire        serial_data_oe_out,
  output wire        serial_aux_out,
  input  wire        t1_count_in
);
  reg  [7:0]  ctrl_reg;
  reg  [2:0]  rate_reg;
  reg  [11:0] t1cfg_reg;
  reg  [15:0] t2rld_reg;
  reg  [7:0]  rxbuf_reg;
  reg         wait_reg;
  reg  [31:0] rdata_reg;
  reg  [15:0] t1_reg;
  reg  [3:0]  t1pre_reg;
  reg         t1prev_reg;
  reg         t1half_reg;
  reg  [15:0] t2_reg;
  reg         t2pre_reg;
  reg  [1:0]  p4_reg;
  reg         m0_act_reg;
  reg         m0_rx_reg;
  reg  [3:0]  m0_div_reg;
  reg  [2:0]  m0_cnt_reg;
  reg  [7:0]  m0_sh_reg;
  reg  [10:0] tx_sh_reg;
  reg  [3:0]  tx_cnt_reg;
  reg  [3:0]  tx_sub_reg;
  reg         tx_line_reg;
  reg         rx_act_reg;
  reg  [3:0]  rx_idx_reg;
  reg  [3:0]  rx_sub_reg;
  reg  [8:0]  rx_sh_reg;
  reg         rx_prev_reg;
  reg         dout_reg;
  reg         doe_reg;
  reg         aux_reg;

  wire [1:0] mode = {ctrl_reg[`URBG_CTRL_SMH], ctrl_reg[`URBG_CTRL_SML]};
  wire rx_enable = ctrl_reg[`URBG_CTRL_REN];
  wire mpf = ctrl_reg[`URBG_CTRL_MPF];
  wire rxf = ctrl_reg[`URBG_CTRL_RXF];
  wire rate_doubling_bit = rate_reg[`URBG_RATE_DBL];
  wire receive_clock_select = rate_reg[`URBG_RATE_RSEL];
  wire transmit_clock_select = rate_reg[`URBG_RATE_TSEL];
  wire [1:0] t1_mode = t1cfg_reg[`URBG_T1_MODE_HI:`URBG_T1_MODE_LO];
  wire [7:0] timer1_reload_byte = t1cfg_reg[7:0];

  // bus: one wait cycle, access takes effect where waitrequest is low
  wire req = avs_read_in | avs_write_in;
  wire wr = avs_write_in & ~wait_reg;
  wire be0 = avs_byteenable_in[0];
  wire be1 = avs_byteenable_in[1];
  wire wr_ctrl = wr & be0 & (avs_address_in == `URBG_ADDR_CTRL);
  wire wr_data = wr & be0 & (avs_address_in == `URBG_ADDR_DATA);
  wire wr_rate = wr & be0 & (avs_address_in == `URBG_ADDR_RATE);
  wire wr_t1 = wr & (avs_address_in == `URBG_ADDR_T1CFG);
  wire wr_t2 = wr & (avs_address_in == `URBG_ADDR_T2RLD);

  reg [31:0] rmux;
  always @* begin
    rmux = 32'h0000_0000;
    case (avs_address_in)
      `URBG_ADDR_CTRL: rmux = {24'h000000, ctrl_reg};
      `URBG_ADDR_DATA: rmux = {24'h000000, rxbuf_reg};
      `URBG_ADDR_RATE: rmux = {29'h0000000, rate_reg};
      `URBG_ADDR_T1CFG: rmux = {20'h00000, t1cfg_reg};
      `URBG_ADDR_T2RLD: rmux = {16'h0000, t2rld_reg};
      `URBG_ADDR_STAT: rmux = {30'h0000000, rx_act_reg | (m0_act_reg & m0_rx_reg),
                               (tx_cnt_reg != 4'h0) | (tx_sub_reg != 4'h0)
                               | (m0_act_reg & ~m0_rx_reg)};
      default: rmux = 32'h0000_0000;
    endcase
  end

  // timer 1: prescaled by a machine cycle or counting pin falls
  wire t1_inc = t1cfg_reg[`URBG_T1_RUN] & (t1cfg_reg[`URBG_T1_CNTR]
                ? (t1prev_reg & ~t1_count_in) : (t1pre_reg == `URBG_T1_PRE_LAST));
  reg [15:0] t1_next;
  reg        t1_ovf;
  always @* begin
    t1_next = t1_reg;
    t1_ovf = 1'b0;
    if (t1_inc) begin
      case (t1_mode)
        2'h0: begin
          t1_ovf = (&t1_reg[15:8]) & (&t1_reg[4:0]);
          if (t1_ovf)
            t1_next = {timer1_reload_byte, 8'h00};
          else if (&t1_reg[4:0])
            t1_next = {t1_reg[15:8] + 8'h01, 8'h00};
          else
            t1_next = {t1_reg[15:8], 3'h0, t1_reg[4:0] + 5'h01};
        end
        2'h1: begin
          t1_ovf = &t1_reg;
          t1_next = t1_ovf ? {timer1_reload_byte, 8'h00} : t1_reg + 16'h0001;
        end
        2'h2: begin
          // auto reload of the low byte gives clk/12/(256-reload) overflows
          t1_ovf = &t1_reg[7:0];
          t1_next = {8'h00, t1_ovf ? timer1_reload_byte : t1_reg[7:0] + 8'h01};
        end
        default: t1_next = t1_reg;
      endcase
    end
  end

  // timer 2 rate mode: counts each second clock, reloads on overflow
  wire t2_on = receive_clock_select | transmit_clock_select;
  wire t2_ovf = t2_on & t2pre_reg & (&t2_reg);

  // sixteen-times bit clocks per direction
  wire t1_tick = t1_ovf & (rate_doubling_bit | t1half_reg);
  wire m2_tick = rate_doubling_bit ? p4_reg[0] : (&p4_reg);
  wire rx_tick = (mode == `URBG_MODE_9FIX) ? m2_tick
               : (receive_clock_select ? t2_ovf : t1_tick);
  wire tx_tick = (mode == `URBG_MODE_9FIX) ? m2_tick
               : (transmit_clock_select ? t2_ovf : t1_tick);
  wire async = mode != `URBG_MODE_SHIFT;
  wire [3:0] nbits = (mode[1]) ? `URBG_BITS_9 : `URBG_BITS_8;

  // shift mode engine
  wire m0_bit_end = m0_act_reg & (m0_div_reg == `URBG_M0_DIV_LAST);
  wire m0_done = m0_bit_end & (m0_cnt_reg == 3'h7);
  wire m0_txf_set = m0_done & ~m0_rx_reg;
  wire m0_rxf_set = m0_done & m0_rx_reg;
  wire m0_rx_start = ~async & ~m0_act_reg & rx_enable & ~rxf & ~wr_data;

  // async transmit: flag raised as the stop bit goes out
  wire tx_drive = tx_tick & (tx_sub_reg == 4'h0) & (tx_cnt_reg != 4'h0);
  wire a_txf_set = tx_drive & (tx_cnt_reg == 4'h1);

  // async receive: sample at mid-bit, last sample is the stop bit middle
  wire rx_start = async & rx_enable & ~rx_act_reg & rx_tick
                & rx_prev_reg & ~serial_data_in;
  wire rx_samp = rx_act_reg & rx_tick & (rx_sub_reg == 4'h0);
  wire rx_last = rx_samp & (rx_idx_reg == nbits - 4'h1);
  wire [7:0] rx_word = mode[1] ? rx_sh_reg[7:0] : rx_sh_reg[8:1];
  wire rx_ninth = mode[1] ? rx_sh_reg[8] : serial_data_in;
  // a frame finishing while the flag is still up is dropped, not queued
  wire rx_keep = rx_last & ~rxf & (~mpf | rx_ninth);
  wire a_rxf_set = rx_keep & async;

  // flags: hardware set wins over a software clear in the same cycle
  wire txf_set = m0_txf_set | a_txf_set;
  wire rxf_set = m0_rxf_set | a_rxf_set;
  wire txf_clr = wr_ctrl & ~avs_writedata_in[`URBG_CTRL_TXF];
  wire rxf_clr = wr_ctrl & ~avs_writedata_in[`URBG_CTRL_RXF];

  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_reg <= `URBG_CTRL_RST;
      rate_reg <= `URBG_RATE_RST;
      t1cfg_reg <= `URBG_T1CFG_RST;
      t2rld_reg <= `URBG_T2RLD_RST;
      rxbuf_reg <= 8'h00;
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      t1_reg <= 16'h0000;
      t1pre_reg <= 4'h0;
      t1prev_reg <= 1'b1;
      t1half_reg <= 1'b0;
      t2_reg <= 16'h0000;
      t2pre_reg <= 1'b0;
      p4_reg <= 2'h0;
      m0_act_reg <= 1'b0;
      m0_rx_reg <= 1'b0;
      m0_div_reg <= 4'h0;
      m0_cnt_reg <= 3'h0;
      m0_sh_reg <= 8'h00;
      tx_sh_reg <= 11'h7FF;
      tx_cnt_reg <= 4'h0;
      tx_sub_reg <= 4'h0;
      tx_line_reg <= 1'b1;
      rx_act_reg <= 1'b0;
      rx_idx_reg <= 4'h0;
      rx_sub_reg <= 4'h0;
      rx_sh_reg <= 9'h000;
      rx_prev_reg <= 1'b1;
      dout_reg <= 1'b1;
      doe_reg <= 1'b0;
      aux_reg <= 1'b1;
    end else begin
      wait_reg <= ~(req & wait_reg);
      if (req & wait_reg)
        rdata_reg <= rmux;
      if (wr_ctrl)
        ctrl_reg[7:3] <= avs_writedata_in[7:3];
      ctrl_reg[`URBG_CTRL_TXF] <= txf_set | (ctrl_reg[`URBG_CTRL_TXF] & ~txf_clr);
      ctrl_reg[`URBG_CTRL_RXF] <= rxf_set | (rxf & ~rxf_clr);
      if (wr_rate)
        rate_reg <= avs_writedata_in[2:0];
      if (wr_t1 & be0)
        t1cfg_reg[7:0] <= avs_writedata_in[7:0];
      if (wr_t1 & be1)
        t1cfg_reg[11:8] <= avs_writedata_in[11:8];
      if (wr_t2 & be0)
        t2rld_reg[7:0] <= avs_writedata_in[7:0];
      if (wr_t2 & be1)
        t2rld_reg[15:8] <= avs_writedata_in[15:8];

      // timers and prescalers
      t1pre_reg <= (t1pre_reg == `URBG_T1_PRE_LAST) ? 4'h0 : t1pre_reg + 4'h1;
      t1prev_reg <= t1_count_in;
      t1_reg <= t1_next;
      if (t1_ovf)
        t1half_reg <= ~t1half_reg;
      t2pre_reg <= ~t2pre_reg;
      if (~t2_on)
        t2_reg <= t2rld_reg;
      else if (t2pre_reg)
        t2_reg <= (&t2_reg) ? t2rld_reg : t2_reg + 16'h0001;
      p4_reg <= p4_reg + 2'h1;

      // shift mode
      if (wr_data & ~async) begin
        m0_act_reg <= 1'b1;
        m0_rx_reg <= 1'b0;
        m0_div_reg <= 4'h0;
        m0_cnt_reg <= 3'h0;
        m0_sh_reg <= avs_writedata_in[7:0];
      end else if (m0_rx_start) begin
        m0_act_reg <= 1'b1;
        m0_rx_reg <= 1'b1;
        m0_div_reg <= 4'h0;
        m0_cnt_reg <= 3'h0;
      end else if (m0_act_reg) begin
        m0_div_reg <= m0_bit_end ? 4'h0 : m0_div_reg + 4'h1;
        if (m0_bit_end) begin
          m0_cnt_reg <= m0_cnt_reg + 3'h1;
          m0_sh_reg <= {m0_rx_reg ? serial_data_in : 1'b1, m0_sh_reg[7:1]};
          if (m0_done)
            m0_act_reg <= 1'b0;
          if (m0_rxf_set)
            rxbuf_reg <= {serial_data_in, m0_sh_reg[7:1]};
        end
      end

      // async transmit, starts on the next bit clock
      if (wr_data & async) begin
        tx_sh_reg <= {1'b1, mode[1] ? ctrl_reg[`URBG_CTRL_TB8] : 1'b1,
                      avs_writedata_in[7:0], 1'b0};
        tx_cnt_reg <= nbits;
        tx_sub_reg <= 4'h0;
      end else if (tx_tick & ((tx_cnt_reg != 4'h0) | (tx_sub_reg != 4'h0))) begin
        if (tx_drive) begin
          tx_line_reg <= tx_sh_reg[0];
          tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
          tx_cnt_reg <= tx_cnt_reg - 4'h1;
          tx_sub_reg <= `URBG_OVS_LAST;
        end else
          tx_sub_reg <= tx_sub_reg - 4'h1;
      end
      if (~async)
        tx_line_reg <= 1'b1;

      // async receive
      if (rx_tick)
        rx_prev_reg <= serial_data_in;
      if (~async | ~rx_enable)
        rx_act_reg <= 1'b0;
      else if (rx_start) begin
        rx_act_reg <= 1'b1;
        rx_idx_reg <= 4'h0;
        rx_sub_reg <= `URBG_RX_MID;
      end else if (rx_act_reg & rx_tick) begin
        if (rx_samp) begin
          rx_sub_reg <= `URBG_OVS_LAST;
          rx_idx_reg <= rx_idx_reg + 4'h1;
          // a start bit that is high again at mid-bit was a glitch
          if ((rx_idx_reg == 4'h0) & serial_data_in)
            rx_act_reg <= 1'b0;
          else if (rx_idx_reg != 4'h0)
            rx_sh_reg <= {serial_data_in, rx_sh_reg[8:1]};
          if (rx_last)
            rx_act_reg <= 1'b0;
          if (rx_keep) begin
            rxbuf_reg <= rx_word;
            ctrl_reg[`URBG_CTRL_RB8] <= rx_ninth;
          end
        end else
          rx_sub_reg <= rx_sub_reg - 4'h1;
      end

      // pins: shift clock idles high, low for the first half of each bit
      aux_reg <= async ? tx_line_reg
               : (~m0_act_reg | (m0_div_reg >= `URBG_M0_HALF));
      dout_reg <= m0_sh_reg[0];
      doe_reg <= ~async & m0_act_reg & ~m0_rx_reg;
    end
  end

  assign avs_readdata_out = rdata_reg;
  assign avs_waitrequest_out = wait_reg;
  assign serial_data_out = dout_reg;
  assign serial_data_oe_out = doe_reg;
  assign serial_aux_out = aux_reg;
endmodule // urbg_top

// *** sim/urbg_remote.sv ***
// behavioural remote serial transceiver on the far side
`timescale 1ns/1ps
module urbg_remote (
  input  wire       clk_in,
  input  wire       line_in,
  input  wire       shift_en_in,
  input  wire [7:0] shift_byte_in,
  output logic      line_out
);
  int          bit_clks = 64;
  logic [10:0] rx_frame;
  logic        aux_q = 1'b1;
  logic [2:0]  sh_idx = 3'h0;
  initial line_out = 1'b1;
  // frame bits given lsb first, last one is the stop bit so the line rests high
  task automatic send(input logic [10:0] bits, input int nb);
    for (int i = 0; i < nb; i++) begin
      line_out <= bits[i];
      repeat (bit_clks) @(posedge clk_in);
    end
  endtask
  // mid-bit sampling tolerates a few cycles of start jitter
  task automatic receive(input int nb);
    rx_frame = 11'h7FF;
    while (line_in !== 1'b0) @(posedge clk_in);
    repeat (bit_clks / 2) @(posedge clk_in);
    for (int i = 0; i < nb; i++) begin
      rx_frame[i] = line_in;
      repeat (bit_clks) @(posedge clk_in);
    end
  endtask
  // next bit goes out as the shift clock falls
  always @(posedge clk_in) begin
    aux_q <= line_in;
    if (!shift_en_in) begin
      sh_idx <= 3'h0;
    end else if (aux_q && !line_in) begin
      line_out <= shift_byte_in[sh_idx];
      sh_idx <= sh_idx + 3'h1;
    end
  end
endmodule // urbg_remote

// *** sim/urbg_top_props.sv ***
// assertion checker for the uart block ports
`timescale 1ns/1ps
module urbg_top_props (
  input wire        clk_in,
  input wire        sys_rst_in,
  input wire [4:0]  avs_address_in,
  input wire        avs_read_in,
  input wire        avs_write_in,
  input wire [31:0] avs_readdata_out,
  input wire        avs_waitrequest_out,
  input wire        serial_data_out,
  input wire        serial_data_oe_out,
  input wire        serial_aux_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  wire req = avs_read_in | avs_write_in;
  a_wait_answer: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("waitrequest not low one cycle after request");
  a_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  a_wait_cause: assert property ($fell(avs_waitrequest_out) |-> $past(req))
    else $error("waitrequest low without request");
  a_unmapped_zero: assert property (avs_read_in && avs_waitrequest_out
    && avs_address_in > 5'h14 |=> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_shift_low: assert property ($fell(serial_aux_out) && serial_data_oe_out
    |-> !serial_aux_out [*6] ##1 serial_aux_out)
    else $error("shift clock low phase not 6 cycles");
  a_shift_high: assert property ($rose(serial_aux_out) && serial_data_oe_out
    |-> serial_aux_out [*6])
    else $error("shift clock high phase too short");
  a_shift_data: assert property (serial_data_oe_out && $past(serial_data_oe_out)
    && !$stable(serial_data_out) |-> $fell(serial_aux_out))
    else $error("shift data moved outside low start");
  a_reset_idle: assert property (@(posedge clk_in) disable iff (1'b0)
    sys_rst_in |=> avs_waitrequest_out && serial_aux_out && !serial_data_oe_out)
    else $error("outputs not idle in reset");
  c_unmapped: cover property (avs_read_in && avs_address_in > 5'h14);
  c_shift_tx: cover property ($fell(serial_aux_out) && serial_data_oe_out);
  c_async_tx: cover property ($fell(serial_aux_out) && !serial_data_oe_out);
endmodule // urbg_top_props
bind urbg_top urbg_top_props u_props (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .serial_data_out(serial_data_out),
  .serial_data_oe_out(serial_data_oe_out), .serial_aux_out(serial_aux_out));

// *** sim/urbg_top_tb.sv ***
// self-checking bench for the uart block
`timescale 1ns/1ps
`include "urbg_map.vh"
module urbg_top_tb;
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [4:0]  adr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata, q;
  logic        wait_req, d_out, d_oe, aux, rem_out;
  logic        sh_en = 1'b0;
  logic [7:0]  sh_byte = 8'h00;
  logic [1:0]  t1_div = 2'h0;
  logic [7:0]  shift_cap = 8'h00;
  logic        aux_q = 1'b1;
  logic [7:0]  b1;
  int          n_mismatch = 0;
  int          tests_run = 0;
  logic [7:0]  tc_ctrl[6] = '{8'h80, 8'h80, 8'hC0, 8'h40, 8'h40, 8'hC0};
  logic [2:0]  tc_rate[6] = '{3'h0, 3'h1, 3'h1, 3'h1, 3'h4, 3'h4};
  logic [11:0] tc_t1[6] = '{12'h000, 12'h000, 12'hAFF, 12'hEFF, 12'h000, 12'h000};
  logic [15:0] tc_t2[6] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'hFFFE, 16'hFFFD};
  int          tc_clks[6] = '{64, 32, 192, 64, 64, 96};
  urbg_top u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req),
    .serial_data_in(d_oe ? d_out : rem_out), .serial_data_out(d_out),
    .serial_data_oe_out(d_oe), .serial_aux_out(aux), .t1_count_in(t1_div[1]));
  urbg_remote u_rem (.clk_in(clk_in), .line_in(aux), .shift_en_in(sh_en),
    .shift_byte_in(sh_byte), .line_out(rem_out));
  always #4 clk_in = ~clk_in;
  // counter input falls once every 4 clocks
  always @(posedge clk_in) begin
    t1_div <= t1_div + 2'h1;
    aux_q <= aux;
    if (d_oe && aux && !aux_q) shift_cap <= {d_out, shift_cap[7:1]};
  end
  function automatic logic [10:0] frame(input logic [7:0] b, input logic n9, input int nb);
    return (nb == 11) ? {1'b1, n9, b, 1'b0} : {2'b11, b, 1'b0};
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk_in);
    while (wait_req !== 1'b0) begin
      @(posedge clk_in);
      n++;
    end
    q = rdata;
    chk("wait cycles", 32'h1, n);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic poll(input int bi);
    int n;
    n = 0;
    bus(1'b0, `URBG_ADDR_CTRL, 32'h0);
    while (q[bi] !== 1'b1 && n < 2000) begin
      bus(1'b0, `URBG_ADDR_CTRL, 32'h0);
      n++;
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk_in);
    n_mismatch++;
    end_sim();
  end
  initial begin
    int nb;
    logic n9;
    b1 = $urandom(32'hA793A3EA);
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    bus(1'b1, 5'h1C, $urandom);
    for (int a = 0; a <= 28; a += 4) begin
      bus(1'b0, a[4:0], 32'h0);
      chk("reset or unmapped read", 32'h0, q);
    end
    // all frame formats and rate sources, transmit side
    for (int i = 0; i < 6; i++) begin
      b1 = $urandom;
      n9 = $urandom;
      nb = tc_ctrl[i][7] ? 11 : 10;
      u_rem.bit_clks = tc_clks[i];
      // reload before select: a running timer 2 only reloads at overflow
      bus(1'b1, `URBG_ADDR_T2RLD, {16'h0, tc_t2[i]});
      bus(1'b1, `URBG_ADDR_T1CFG, {20'h0, tc_t1[i]});
      bus(1'b1, `URBG_ADDR_RATE, {29'h0, tc_rate[i]});
      bus(1'b1, `URBG_ADDR_CTRL, {24'h0, tc_ctrl[i] | {4'h0, n9, 3'h0}});
      bus(1'b1, `URBG_ADDR_DATA, {24'h0, b1});
      u_rem.receive(nb);
      chk("tx frame", {21'h0, frame(b1, n9, nb)}, {21'h0, u_rem.rx_frame});
      bus(1'b0, `URBG_ADDR_CTRL, 32'h0);
      chk("tx flag", 32'h1, {31'h0, q[`URBG_CTRL_TXF]});
    end
    // receive on timer 2 while transmit stays on timer 1
    u_rem.bit_clks = 64;
    bus(1'b1, `URBG_ADDR_RATE, 32'h2);
    bus(1'b1, `URBG_ADDR_T2RLD, 32'hFFFE);
    bus(1'b1, `URBG_ADDR_CTRL, 32'hC0);
    u_rem.send(frame(8'h5A, 1'b1, 11), 11);
    bus(1'b0, `URBG_ADDR_CTRL, 32'h0);
    chk("ctrl rx disabled", 32'hC0, q);
    bus(1'b1, `URBG_ADDR_CTRL, 32'hF0);
    u_rem.send(frame(8'hA5, 1'b0, 11), 11);
    bus(1'b0, `URBG_ADDR_CTRL, 32'h0);
    chk("ctrl filtered", 32'hF0, q);
    b1 = $urandom;
    u_rem.send(frame(b1, 1'b1, 11), 11);
    poll(`URBG_CTRL_RXF);
    chk("ctrl rx done", 32'hF5, q);
    u_rem.send(frame(~b1, 1'b1, 11), 11);
    bus(1'b0, `URBG_ADDR_DATA, 32'h0);
    chk("rx byte kept", {24'h0, b1}, q);
    // shift register mode, both directions
    bus(1'b1, `URBG_ADDR_CTRL, 32'h00);
    b1 = $urandom;
    bus(1'b1, `URBG_ADDR_DATA, {24'h0, b1});
    poll(`URBG_CTRL_TXF);
    chk("shift tx byte", {24'h0, b1}, {24'h0, shift_cap});
    b1 = $urandom;
    sh_byte <= b1;
    sh_en <= 1'b1;
    bus(1'b1, `URBG_ADDR_CTRL, 32'h10);
    poll(`URBG_CTRL_RXF);
    bus(1'b0, `URBG_ADDR_DATA, 32'h0);
    chk("shift rx byte", {24'h0, b1}, q);
    end_sim();
  end
endmodule // urbg_top_tb
